// >>> hdl/clia_pkg.sv
// Shared constants and carrier types for the core local interrupt acceptor
package clia_pkg;
  // Base control register and its fields
  localparam logic [31:0] MSR_BASE_CTRL = 32'h0000_001B;
  localparam int          BOOT_BIT      = 8;
  localparam int          XMODE_BIT     = 10;
  localparam int          GE_BIT        = 11;
  localparam int          BASE_LSB      = 12;
  localparam int          BASE_MSB      = 51;
  localparam logic [39:0] BASE_RESET    = 40'h00_000F_EE00;
  localparam logic        GE_RESET      = 1'b1;
  // Memory-mapped offsets
  localparam logic [11:0] OFF_EOI       = 12'h0B0;
  localparam logic [11:0] OFF_SPUR      = 12'h0F0;
  localparam logic [4:0]  BLK_ISR       = 5'h02;
  localparam logic [4:0]  BLK_TMR       = 5'h03;
  localparam logic [4:0]  BLK_IRR       = 5'h04;
  localparam logic [11:0] OFF_ENTRY_LO  = 12'h320;
  localparam logic [11:0] OFF_ENTRY_HI  = 12'h370;
  localparam logic [11:0] OFF_XLVT_LO   = 12'h500;
  localparam logic [11:0] OFF_XLVT_HI   = 12'h530;
  localparam logic [3:0]  XLVT_BASE_IDX = 4'h6;
  localparam logic [3:0]  ENT_NONE      = 4'hF;
  // Spurious register and vector entries
  localparam logic [31:0] SPUR_RESET    = 32'h0000_00FF;
  localparam logic [31:0] SPUR_WMASK    = 32'h0000_01FF;
  localparam int          SWEN_BIT      = 8;
  localparam logic [31:0] ENTRY_RESET   = 32'h0001_0000;
  localparam int          NUM_ENTRY     = 10;
  localparam int          ENT_ERROR     = 5;
  // Incoming message type codes
  localparam logic [3:0]  MT_FIXED      = 4'h0;
  localparam logic [3:0]  MT_LOWEST     = 4'h1;
  localparam logic [3:0]  MT_SMI        = 4'h2;
  localparam logic [3:0]  MT_RREAD      = 4'h3;
  localparam logic [3:0]  MT_NMI        = 4'h4;
  localparam logic [3:0]  MT_INIT       = 4'h5;
  localparam logic [3:0]  MT_START      = 4'h6;
  localparam logic [3:0]  MT_EXTERNAL   = 4'h7;
  localparam logic [3:0]  MT_LINE0      = 4'h8;
  localparam logic [3:0]  MT_LINE1      = 4'h9;
  // Local entry type codes
  localparam logic [2:0]  LT_FIXED      = 3'h0;
  localparam logic [2:0]  LT_SMI        = 3'h2;
  localparam logic [2:0]  LT_NMI        = 3'h4;
  localparam logic [2:0]  LT_EXTERNAL   = 3'h7;

  typedef struct packed {
    logic [7:0] vector;
    logic [3:0] mtype;
    logic       level;
  } clia_msg_t;

  typedef struct packed {
    logic [14:0] rsvd_hi;
    logic        mask;
    logic        level;
    logic [3:0]  rsvd_mid;
    logic [2:0]  mtype;
    logic [7:0]  vector;
  } clia_entry_t;

  typedef struct packed {
    logic       fire;
    logic       level;
    logic [2:0] mtype;
    logic [7:0] vector;
  } clia_fire_t;

  typedef struct packed {
    logic maskable_interrupt_line;
    logic system_management_interrupt;
    logic nmi;
    logic init;
    logic startup;
  } clia_lines_t;
endpackage

// >>> hdl/clia_vec_entry.sv
// One local vector-table entry with its source edge detector
`timescale 1ns/1ps
module clia_vec_entry #(
  parameter logic [3:0] ALLOW = 4'hF
) (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 init_event,
  input  wire logic                 global_enable,
  input  wire logic                 software_enable,
  input  wire logic                 wr_en,
  input  wire logic [31:0]          wr_data,
  input  wire logic                 src,
  output clia_pkg::clia_entry_t     entry_q,
  output clia_pkg::clia_fire_t      fire
);
  logic                  src_q;
  clia_pkg::clia_entry_t wr_ent;

  // Map a requested type onto an allowed one, fixed otherwise
  function automatic logic [2:0] legal_type(input logic [2:0] t);
    logic ok;
    ok = (t == clia_pkg::LT_FIXED && ALLOW[0]) || (t == clia_pkg::LT_SMI && ALLOW[1]) ||
         (t == clia_pkg::LT_NMI && ALLOW[2]) || (t == clia_pkg::LT_EXTERNAL && ALLOW[3]);
    return ok ? t : clia_pkg::LT_FIXED;
  endfunction

  assign wr_ent = clia_pkg::clia_entry_t'(wr_data);

  // Entry storage; mask held set while software enable is low
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      entry_q <= clia_pkg::clia_entry_t'(clia_pkg::ENTRY_RESET);
    end else if (wr_en) begin
      entry_q          <= '0;
      entry_q.vector   <= wr_ent.vector;
      entry_q.mtype    <= legal_type(wr_ent.mtype);
      entry_q.level    <= wr_ent.level;
      entry_q.mask     <= wr_ent.mask | ~software_enable;
    end else if (!software_enable) begin
      entry_q.mask <= 1'b1;
    end
  end

  // Rising edge of the source raises one request
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      src_q <= 1'b0;
      fire  <= '0;
    end else begin
      src_q        <= src;
      fire.fire    <= src & ~src_q & ~entry_q.mask & global_enable & software_enable;
      fire.level   <= entry_q.level;
      fire.mtype   <= entry_q.mtype;
      fire.vector  <= entry_q.vector;
    end
  end

  mask_forced_a: assert property (@(posedge ref_clk) disable iff (reset)
    !software_enable && !init_event |=> entry_q.mask)
    else $error("entry mask not forced while software disabled");

  fire_unmasked_a: assert property (@(posedge ref_clk) disable iff (reset)
    fire.fire |-> $past(!entry_q.mask && global_enable))
    else $error("entry fired while masked or disabled");
endmodule

// >>> hdl/clia_req_bank.sv
// Request, in-service and trigger-mode vectors with end-of-interrupt return
`timescale 1ns/1ps
module clia_req_bank (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic         init_event,
  input  wire logic [255:0] set_bits,
  input  wire logic [255:0] set_level,
  input  wire logic         ack,
  input  wire logic         end_of_interrupt,
  output logic      [255:0] request_register,
  output logic      [255:0] in_service_register,
  output logic      [255:0] tmr,
  output logic              irr_any,
  output logic      [7:0]   irr_top,
  output logic              eoi_valid,
  output logic      [7:0]   eoi_vector
);
  logic [8:0]   irr_hi;
  logic [8:0]   isr_hi;
  logic [255:0] ack_bit;
  logic [255:0] eoi_bit;

  // Highest set bit: found flag above the index
  function automatic logic [8:0] top_of(input logic [255:0] v);
    logic [8:0] r;
    r = '0;
    for (int i = 0; i < 256; i++) begin
      if (v[i]) begin
        r = {1'b1, 8'(i)};
      end
    end
    return r;
  endfunction

  assign irr_hi  = top_of(request_register);
  assign isr_hi  = top_of(in_service_register);
  assign irr_any = irr_hi[8];
  assign irr_top = irr_hi[7:0];
  assign ack_bit = (ack && irr_hi[8]) ? (256'h1 << irr_hi[7:0]) : '0;
  assign eoi_bit = (end_of_interrupt && isr_hi[8]) ? (256'h1 << isr_hi[7:0]) : '0;

  // Request vector; a new request wins over the acknowledge clear
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      request_register <= '0;
    end else begin
      request_register <= (request_register & ~ack_bit) | set_bits;
    end
  end

  // In-service vector, held whatever the enables do
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      in_service_register <= '0;
    end else begin
      in_service_register <= (in_service_register & ~eoi_bit) | ack_bit;
    end
  end

  // Trigger mode recorded with each request
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      tmr <= '0;
    end else begin
      tmr <= (tmr & ~set_bits) | (set_bits & set_level);
    end
  end

  // Level requests return an end-of-interrupt to their source
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      eoi_valid  <= 1'b0;
      eoi_vector <= 8'h00;
    end else begin
      eoi_valid  <= end_of_interrupt && isr_hi[8] && tmr[isr_hi[7:0]];
      eoi_vector <= isr_hi[7:0];
    end
  end

  set_captured_a: assert property (@(posedge ref_clk) disable iff (reset || init_event)
    (($past(set_bits) & ~request_register) == 256'h0))
    else $error("request bit lost");

  eoi_level_a: assert property (@(posedge ref_clk) disable iff (reset || init_event)
    eoi_valid |-> $past(end_of_interrupt) && $past(tmr[isr_hi[7:0]]))
    else $error("end-of-interrupt without level request");
endmodule

// >>> hdl/clia_acceptor.sv
// Core local interrupt acceptor: base control, entries, message intake, core lines
`timescale 1ns/1ps
// Function
// - Timer countdown zero raises fixed local interrupt
// - Counter overflow raises interrupt via own entry
// - Thermal trip raises interrupt via thermal entry
// - Four extended sources, each with own entry
// - Internal error raises interrupt via error entry
// - I/O messages edge or level, many types
// - Interprocessor messages, many types, self allowed
// - Vector captured only for fixed, lowest priority, external
// - Level interrupts return end-of-interrupt to source
// - Four-bit type; SMI, NMI, INIT, startup go straight to core
// - Five interrupt lines drive the core
// - Entries hold vector, trigger, type, mask
// - Global enable low blocks all interrupts except requests already pending
// - Software disabled still takes SYSTEM_MANAGEMENT_INTERRUPT, NMI, INIT
// - Software disabled keeps pending requests held
// - Software disabled rejects fixed, lowest, external
// - Software disabled forces masks set
// - Base field bits 51:12, read-write
// - Base field resets fixed, survives init
// - Bit 8 reports boot core, read-only
// - Bit 10 extended mode; reserved read zero
module clia_acceptor (
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic                 init_event,
  input  wire logic                 boot_core_strap,
  input  wire logic                 msr_wr,
  input  wire logic                 msr_rd,
  input  wire logic [31:0]          msr_addr,
  input  wire logic [63:0]          msr_wdata,
  output logic      [63:0]          msr_rdata,
  input  wire logic                 mem_req,
  input  wire logic                 mem_we,
  input  wire logic [51:0]          mem_addr,
  input  wire logic [31:0]          mem_wdata,
  output logic      [31:0]          mem_rdata,
  output logic                      mem_rvalid,
  input  wire logic                 msg_valid,
  input  wire clia_pkg::clia_msg_t  msg,
  output logic                      msg_rejected,
  input  wire logic                 timer_zero,
  input  wire logic                 perf_overflow,
  input  wire logic                 thermal_trip,
  input  wire logic [3:0]           ext_src,
  output clia_pkg::clia_lines_t     core_lines,
  input  wire logic                 core_ack,
  output logic      [7:0]           core_vector,
  output logic                      eoi_valid,
  output logic      [7:0]           eoi_vector
);
  logic [39:0]           register_base_field;
  logic                  global_enable;
  logic                  extended_mode_enable;
  logic                  boot_core_flag;
  logic                  boot_seen;
  logic [31:0]           spurious_vector_reg;
  logic                  software_enable;
  clia_pkg::clia_entry_t entry_q [clia_pkg::NUM_ENTRY];
  clia_pkg::clia_fire_t  fire    [clia_pkg::NUM_ENTRY];
  logic [9:0]            ent_wr;
  logic [9:0]            src_vec;
  logic                  mem_hit;
  logic                  mem_wr;
  logic [11:0]           off;
  logic [3:0]            ent_idx;
  logic [31:0]           next_rdata;
  logic                  unmapped;
  logic                  err_evt;
  logic                  line0_evt;
  logic                  line1_evt;
  logic                  next_line0;
  logic                  next_line1;
  logic                  next_reject;
  logic                  next_illegal;
  logic                  next_smi;
  logic                  next_nmi;
  logic                  next_init;
  logic                  next_start;
  logic                  ext_take;
  logic [7:0]            ext_take_vec;
  logic                  ext_pend;
  logic [7:0]            ext_vec;
  logic [255:0]          set_bits;
  logic [255:0]          set_level;
  logic [255:0]          request_register;
  logic [255:0]          in_service_register;
  logic [255:0]          tmr;
  logic                  irr_any;
  logic [7:0]            irr_top;

  // Entry index for a register offset, or none
  function automatic logic [3:0] entry_of(input logic [11:0] o);
    logic [11:0] d;
    d = '0;
    if (o[3:0] != 4'h0) begin
      return clia_pkg::ENT_NONE;
    end
    if (o >= clia_pkg::OFF_ENTRY_LO && o <= clia_pkg::OFF_ENTRY_HI) begin
      d = o - clia_pkg::OFF_ENTRY_LO;
      return d[7:4];
    end
    if (o >= clia_pkg::OFF_XLVT_LO && o <= clia_pkg::OFF_XLVT_HI) begin
      d = o - clia_pkg::OFF_XLVT_LO;
      return clia_pkg::XLVT_BASE_IDX + d[7:4];
    end
    return clia_pkg::ENT_NONE;
  endfunction

  assign software_enable = spurious_vector_reg[clia_pkg::SWEN_BIT];

  // Base control register; init leaves it untouched
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      register_base_field  <= clia_pkg::BASE_RESET;
      global_enable        <= clia_pkg::GE_RESET;
      extended_mode_enable <= 1'b0;
    end else if (msr_wr && msr_addr == clia_pkg::MSR_BASE_CTRL) begin
      register_base_field  <= msr_wdata[clia_pkg::BASE_MSB:clia_pkg::BASE_LSB];
      global_enable        <= msr_wdata[clia_pkg::GE_BIT];
      extended_mode_enable <= msr_wdata[clia_pkg::XMODE_BIT];
    end
  end

  // Boot core strap caught once after reset release
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      boot_seen      <= 1'b0;
      boot_core_flag <= 1'b0;
    end else if (!boot_seen) begin
      boot_seen      <= 1'b1;
      boot_core_flag <= boot_core_strap;
    end
  end

  // Base control read; reserved bits read as zero
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      msr_rdata <= 64'h0;
    end else if (msr_rd) begin
      msr_rdata <= (msr_addr == clia_pkg::MSR_BASE_CTRL) ?
                   {12'h000, register_base_field, global_enable, extended_mode_enable,
                    1'b0, boot_core_flag, 8'h00} : 64'h0;
    end
  end

  // Memory-mapped decode at base plus offset
  assign mem_hit = mem_req && mem_addr[51:12] == register_base_field;
  assign mem_wr  = mem_hit && mem_we;
  assign off     = mem_addr[11:0];
  assign ent_idx = entry_of(off);

  // Spurious register holds the software enable
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      spurious_vector_reg <= clia_pkg::SPUR_RESET;
    end else if (mem_wr && off == clia_pkg::OFF_SPUR) begin
      spurious_vector_reg <= mem_wdata & clia_pkg::SPUR_WMASK;
    end
  end

  // Read mux over the mapped registers
  always_comb begin
    next_rdata = 32'h0;
    unmapped   = 1'b0;
    if (ent_idx != clia_pkg::ENT_NONE) begin
      next_rdata = entry_q[ent_idx];
    end else if (off == clia_pkg::OFF_SPUR) begin
      next_rdata = spurious_vector_reg;
    end else if (off[3:0] == 4'h0 && off[11:7] == clia_pkg::BLK_ISR) begin
      next_rdata = in_service_register[{off[6:4], 5'h00} +: 32];
    end else if (off[3:0] == 4'h0 && off[11:7] == clia_pkg::BLK_TMR) begin
      next_rdata = tmr[{off[6:4], 5'h00} +: 32];
    end else if (off[3:0] == 4'h0 && off[11:7] == clia_pkg::BLK_IRR) begin
      next_rdata = request_register[{off[6:4], 5'h00} +: 32];
    end else if (off != clia_pkg::OFF_EOI) begin
      unmapped = 1'b1;
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      mem_rvalid <= 1'b0;
      mem_rdata  <= 32'h0;
    end else begin
      mem_rvalid <= mem_req && !mem_we;
      mem_rdata  <= mem_hit ? next_rdata : 32'h0;
    end
  end

  // Local sources in entry order
  assign src_vec = {ext_src, err_evt, line1_evt, line0_evt, perf_overflow, thermal_trip, timer_zero};

  // One entry per local source; allowed types per source
  for (genvar i = 0; i < clia_pkg::NUM_ENTRY; i++) begin : g_ent
    localparam logic [3:0] ALW = (i == 0) ? 4'h1 : (i == 3 || i == 4 || i >= 6) ? 4'hF : 4'h7;
    assign ent_wr[i] = mem_wr && ent_idx == 4'(i);
    clia_vec_entry #(.ALLOW(ALW)) u_ent (
      .ref_clk         (ref_clk),
      .reset           (reset),
      .init_event      (init_event),
      .global_enable   (global_enable),
      .software_enable (software_enable),
      .wr_en           (ent_wr[i]),
      .wr_data         (mem_wdata),
      .src             (src_vec[i]),
      .entry_q         (entry_q[i]),
      .fire            (fire[i])
    );
  end

  // Message type decode and local fire routing
  always_comb begin
    next_reject  = 1'b0;
    next_illegal = 1'b0;
    next_smi     = 1'b0;
    next_nmi     = 1'b0;
    next_init    = 1'b0;
    next_start   = 1'b0;
    next_line0   = 1'b0;
    next_line1   = 1'b0;
    ext_take     = 1'b0;
    ext_take_vec = 8'h00;
    set_bits     = '0;
    set_level    = '0;
    for (int i = 0; i < clia_pkg::NUM_ENTRY; i++) begin
      if (fire[i].fire) begin
        unique case (fire[i].mtype)
          clia_pkg::LT_SMI:    next_smi = 1'b1;
          clia_pkg::LT_NMI:    next_nmi = 1'b1;
          clia_pkg::LT_EXTERNAL: begin
            ext_take     = 1'b1;
            ext_take_vec = fire[i].vector;
          end
          default: begin
            set_bits[fire[i].vector]  = 1'b1;
            set_level[fire[i].vector] = fire[i].level;
          end
        endcase
      end
    end
    if (msg_valid) begin
      if (!global_enable) begin
        next_reject = 1'b1;
      end else begin
        case (msg.mtype)
          clia_pkg::MT_FIXED, clia_pkg::MT_LOWEST: begin
            if (software_enable) begin
              set_bits[msg.vector]  = 1'b1;
              set_level[msg.vector] = msg.level;
            end else begin
              next_reject = 1'b1;
            end
          end
          clia_pkg::MT_EXTERNAL: begin
            if (software_enable) begin
              ext_take     = 1'b1;
              ext_take_vec = msg.vector;
            end else begin
              next_reject = 1'b1;
            end
          end
          clia_pkg::MT_SMI:    next_smi   = 1'b1;
          clia_pkg::MT_NMI:    next_nmi   = 1'b1;
          clia_pkg::MT_INIT:   next_init  = 1'b1;
          clia_pkg::MT_START:  next_start = 1'b1;
          clia_pkg::MT_RREAD:  next_reject = 1'b0;
          clia_pkg::MT_LINE0:  next_line0 = 1'b1;
          clia_pkg::MT_LINE1:  next_line1 = 1'b1;
          default: begin
            next_reject  = 1'b1;
            next_illegal = 1'b1;
          end
        endcase
      end
    end
  end

  // Rejection, error and local-line event pulses
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      msg_rejected <= 1'b0;
      err_evt      <= 1'b0;
      line0_evt    <= 1'b0;
      line1_evt    <= 1'b0;
    end else begin
      msg_rejected <= next_reject;
      err_evt      <= next_illegal | (mem_hit & unmapped);
      line0_evt    <= next_line0;
      line1_evt    <= next_line1;
    end
  end

  // External-interrupt vector waits for the core acknowledge
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      ext_pend <= 1'b0;
      ext_vec  <= 8'h00;
    end else if (ext_take) begin
      ext_pend <= 1'b1;
      ext_vec  <= ext_take_vec;
    end else if (core_ack) begin
      ext_pend <= 1'b0;
    end
  end

  // Five core lines and the acknowledged vector
  always_ff @(posedge ref_clk) begin
    if (reset || init_event) begin
      core_lines  <= '0;
      core_vector <= 8'h00;
    end else begin
      core_lines.maskable_interrupt_line    <= irr_any | ext_pend;
      core_lines.system_management_interrupt     <= next_smi;
      core_lines.nmi     <= next_nmi;
      core_lines.init    <= next_init;
      core_lines.startup <= next_start;
      if (core_ack) begin
        core_vector <= ext_pend ? ext_vec : irr_top;
      end
    end
  end

  clia_req_bank u_bank (
    .ref_clk    (ref_clk),
    .reset      (reset),
    .init_event (init_event),
    .set_bits   (set_bits),
    .set_level  (set_level),
    .ack        (core_ack && !ext_pend),
    .end_of_interrupt        (mem_wr && off == clia_pkg::OFF_EOI),
    .request_register        (request_register),
    .in_service_register        (in_service_register),
    .tmr        (tmr),
    .irr_any    (irr_any),
    .irr_top    (irr_top),
    .eoi_valid  (eoi_valid),
    .eoi_vector (eoi_vector)
  );

  base_reset_a: assert property (@(posedge ref_clk)
    $past(reset) && !reset |-> register_base_field == clia_pkg::BASE_RESET)
    else $error("base field reset value wrong");

  base_init_a: assert property (@(posedge ref_clk) disable iff (reset)
    init_event && !msr_wr |=> $stable(register_base_field))
    else $error("base field changed on init");

  fixed_reject_a: assert property (@(posedge ref_clk) disable iff (reset || init_event)
    msg_valid && msg.mtype == clia_pkg::MT_FIXED && !software_enable |=> msg_rejected)
    else $error("fixed message taken while software disabled");

  smi_pass_a: assert property (@(posedge ref_clk) disable iff (reset || init_event)
    msg_valid && msg.mtype == clia_pkg::MT_SMI && global_enable |=> core_lines.system_management_interrupt)
    else $error("system management message not delivered");

  global_off_a: assert property (@(posedge ref_clk) disable iff (reset)
    $past(!global_enable) && $past(global_enable, 2) == 1'b0 |-> !(core_lines.system_management_interrupt || core_lines.nmi ||
      core_lines.init || core_lines.startup))
    else $error("line pulse while globally disabled");

  ext_mode_write_a: assert property (@(posedge ref_clk) disable iff (reset)
    msr_wr && msr_addr == clia_pkg::MSR_BASE_CTRL |=> extended_mode_enable == $past(msr_wdata[clia_pkg::XMODE_BIT]))
    else $error("extended mode bit not written");
endmodule

// >>> tb/clia_core_model.sv
// Core-side model that acknowledges the maskable line after a chosen delay
`timescale 1ns/1ps
module clia_core_model (
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire clia_pkg::clia_lines_t core_lines,
  input  wire logic [3:0]            delay,
  output logic                       core_ack,
  output logic                       got
);
  logic [3:0] cnt;
  logic       done;
  // One acknowledge each time the maskable line rises, then wait for the line to drop
  always_ff @(posedge ref_clk) begin
    got      <= core_ack & ~reset;
    core_ack <= 1'h0;
    if (reset || !core_lines.maskable_interrupt_line) begin
      cnt  <= 4'h0;
      done <= 1'h0;
    end else if (!done) begin
      cnt <= cnt + 4'h1;
      if (cnt == delay) begin
        core_ack <= 1'h1;
        done     <= 1'h1;
      end
    end
  end
endmodule

// >>> tb/test_core_local_interrupt_acceptor.sv
// Self-checking bench for the core local interrupt acceptor
`timescale 1ns/1ps
module test_core_local_interrupt_acceptor;
  logic                  ref_clk = 1'h0, reset = 1'h1, init_event = 1'h0, msr_wr = 1'h0, msr_rd = 1'h0;
  logic                  mem_req = 1'h0, mem_we = 1'h0, msg_valid = 1'h0, timer_zero = 1'h0;
  logic                  msg_rejected, core_ack, got, mem_rvalid, eoi_valid;
  logic [31:0]           mem_wdata = 32'h0, mem_rdata;
  logic [63:0]           msr_wdata = 64'h0, msr_rdata;
  logic [51:0]           mem_addr = 52'h0;
  logic [39:0]           base = 40'h0;
  logic [7:0]            core_vector, eoi_vector, v;
  logic [3:0]            delay = 4'h0;
  logic                  boot = 1'h0;
  logic [31:0]           msr_addr = 32'h1B;
  clia_pkg::clia_msg_t   msg = '0;
  clia_pkg::clia_lines_t core_lines;
  logic [15:0]           q[$];
  logic [3:0]            typ[7] = '{4'h0, 4'h1, 4'h7, 4'h2, 4'h4, 4'h5, 4'h6};
  logic [15:0]           ex[7] = '{16'h1000, 16'h1000, 16'h1000, 16'h0208, 16'h0204, 16'h0202, 16'h0201};
  int                    mismatches = 0, comparisons = 0, cycles = 0;

  clia_acceptor dut (.ref_clk(ref_clk), .reset(reset), .init_event(init_event), .boot_core_strap(boot),
    .msr_wr(msr_wr), .msr_rd(msr_rd), .msr_addr(msr_addr), .msr_wdata(msr_wdata), .msr_rdata(msr_rdata),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_rvalid(mem_rvalid), .msg_valid(msg_valid), .msg(msg), .msg_rejected(msg_rejected),
    .timer_zero(timer_zero), .perf_overflow(1'h0), .thermal_trip(1'h0), .ext_src(4'h0),
    .core_lines(core_lines), .core_ack(core_ack), .core_vector(core_vector), .eoi_valid(eoi_valid),
    .eoi_vector(eoi_vector));
  clia_core_model partner (.ref_clk(ref_clk), .reset(reset), .core_lines(core_lines), .delay(delay),
    .core_ack(core_ack), .got(got));

  always #2.5 ref_clk = ~ref_clk;

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic results();
    if (q.size() > 0) begin
      mismatches += q.size();
      $display("MISMATCH t=%0t got=%h exp=%h", $time, 16'hFFFF, q[0]);
    end
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Event results: oldest note against what the outputs show
  task automatic chk(input logic [15:0] g);
    logic [15:0] e;
    e = q.size() ? q.pop_front() : 16'hFFFF;
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Control register read against an expected word
  task automatic msr_r(input logic [63:0] e);
    msr_rd = 1'h1;
    cyc(1);
    msr_rd = 1'h0;
    cyc(1);
    comparisons++;
    if (msr_rdata !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, msr_rdata, e);
    end
  endtask
  task automatic msr_w(input logic [63:0] d);
    msr_wr = 1'h1;
    msr_wdata = d;
    cyc(1);
    msr_wr = 1'h0;
  endtask
  task automatic mw(input logic [11:0] off, input logic [31:0] d);
    mem_req = 1'h1;
    mem_we = 1'h1;
    mem_addr = {base, off};
    mem_wdata = d;
    cyc(1);
    mem_req = 1'h0;
    cyc(1);
  endtask
  // Register read: answer stands one cycle after the request
  task automatic mr(input logic [11:0] off, input logic [31:0] e);
    mem_req = 1'h1;
    mem_we = 1'h0;
    mem_addr = {base, off};
    cyc(1);
    mem_req = 1'h0;
    comparisons++;
    if ({mem_rvalid, mem_rdata} !== {1'h1, e}) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, {mem_rvalid, mem_rdata}, {1'h1, e});
    end
    cyc(1);
  endtask
  // One message, then wait for every noted result to show
  task automatic send(input logic [3:0] t, input logic l, input logic [15:0] e);
    msg = '{v, t, l};
    msg_valid = 1'h1;
    q.push_back(e);
    cyc(1);
    msg_valid = 1'h0;
    for (int i = 0; i < 40 && q.size() > 0; i++) cyc(1);
    cyc(2);
  endtask

  // Watch the outputs for one result per cycle
  always @(negedge ref_clk) begin
    if (!reset && msg_rejected) chk(16'h1000);
    else if (!reset && core_lines[3:0] != 4'h0) chk({12'h020, core_lines[3:0]});
    else if (!reset && eoi_valid) chk({8'h30, eoi_vector});
    else if (!reset && got) chk({8'h40, core_vector});
  end
  // Cut a hang short
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    void'($urandom(32'h2A36));
    boot = 1'($urandom);
    cyc(8);
    reset = 1'h0;
    cyc(2);
    msr_r({12'h0, 40'hFEE00, 3'h4, boot, 8'h00});
    base = {8'($urandom), $urandom};
    msr_w({12'hFFF, base, 12'hFFF});
    msr_r({12'h0, base, 3'h6, boot, 8'h00});
    msr_addr = 32'h1C;
    msr_w(64'h0);
    msr_r(64'h0);
    msr_addr = 32'h1B;
    init_event = 1'h1;
    cyc(1);
    init_event = 1'h0;
    msr_r({12'h0, base, 3'h6, boot, 8'h00});
    for (int i = 0; i < 7; i++) send(typ[i], 1'h0, ex[i]);
    mw(12'h0F0, 32'h1FF);
    for (int i = 0; i < 2; i++) begin
      v = 8'($urandom);
      delay = 4'($urandom);
      send(4'(i), !i[0], {8'h40, v});
      if (!i[0]) q.push_back({8'h30, v});
      mw(12'h0B0, 32'h0);
      cyc(2);
    end
    v = 8'($urandom);
    mw(12'h320, {24'h0, v});
    q.push_back({8'h40, v});
    timer_zero = 1'h1;
    cyc(30);
    timer_zero = 1'h0;
    mw(12'h0F0, 32'h0FF);
    mr({4'h1, 1'h0, v[7:5], 4'h0}, 32'h1 << v[4:0]);
    mw(12'h320, {24'h0, v});
    mr(12'h320, {15'h0, 1'h1, 8'h00, v});
    timer_zero = 1'h1;
    cyc(30);
    msr_w({12'h0, base, 12'h100});
    send(4'h4, 1'h0, 16'h1000);
    results();
  end
endmodule
